// ### rtl/sfe_ctrl.sv
`timescale 1ns/1ps
module sfe_ctrl
    import sfe_pkg::*;
#(
    parameter int SE_TIME_US = 100000,
    parameter int B32_TIME_US = 200000,
    parameter int B64_TIME_US = 300000,
    parameter int CE_TIME_US = 100000000,
    parameter int PP_TIME_US = 1000
) (
    // system
    input wire logic clk_sys,
    input wire logic nrst,
    // serial link
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_di,
    output logic spi_do,
    output logic spi_do_oe_n,
    // configuration
    input wire logic addr4_mode,
    input wire logic quad_io_enable,
    input wire logic protect_complement,
    input wire logic protect_top_bottom,
    input wire logic protect_range_bit3,
    input wire logic protect_range_bit2,
    input wire logic protect_range_bit1,
    input wire logic protect_range_bit0,
    // protection lookup
    output logic [31:0] prot_addr,
    output logic [31:0] prot_len,
    output logic prot_whole,
    input wire logic prot_hit,
    // status
    output logic busy,
    output logic write_enable_latch,
    output logic paused_flag,
    // array engine
    output logic op_start,
    output logic op_erase,
    output logic [31:0] op_base,
    output logic [31:0] op_len,
    output logic [7:0] op_fill,
    output logic op_paused,
    output logic op_done
);
    localparam logic [31:0] SE_CYC = us_to_cyc(SE_TIME_US);
    localparam logic [31:0] B32_CYC = us_to_cyc(B32_TIME_US);
    localparam logic [31:0] B64_CYC = us_to_cyc(B64_TIME_US);
    localparam logic [31:0] CE_CYC = us_to_cyc(CE_TIME_US);
    localparam logic [31:0] PP_CYC = us_to_cyc(PP_TIME_US);

    function automatic logic frame_ok(input logic [CNT_W-1:0] cnt,
                                      input logic [CNT_W-1:0] hdr,
                                      input logic exact,
                                      input logic quad);
        logic [CNT_W-1:0] d;
        d = cnt - hdr;
        if (exact)
            return cnt == hdr;
        else if (quad)
            return (cnt >= hdr + QUAD_BYTE_CLKS) && !d[0];
        else
            return (cnt >= hdr + BYTE_CLKS) && (d[2:0] == 3'h0);
    endfunction

    function automatic logic [31:0] kind_len(input sfe_kind_e k);
        case (k)
            KD_SE: return SECTOR_BYTES;
            KD_B32: return BLK32_BYTES;
            KD_B64: return BLK64_BYTES;
            KD_CE: return ARRAY_BYTES;
            default: return PAGE_BYTES;
        endcase
    endfunction

    function automatic logic [31:0] kind_cyc(input sfe_kind_e k);
        case (k)
            KD_SE: return SE_CYC;
            KD_B32: return B32_CYC;
            KD_B64: return B64_CYC;
            KD_CE: return CE_CYC;
            default: return PP_CYC;
        endcase
    endfunction

    // ---------------- link domain ----------------
    logic fresh;
    logic [CNT_W-1:0] lk_cnt;
    logic [7:0] lk_op;
    logic [31:0] lk_addr;
    logic [15:0] lk_status;
    logic rd_on;
    logic [15:0] st_word;
    logic [15:0] next_st_word;

    // chip select high arms a restart of the frame counters
    always_ff @(posedge spi_clk or posedge spi_cs_n) begin
        if (spi_cs_n)
            fresh <= 1'b1;
        else
            fresh <= 1'b0;
    end

    // clocks of the frame; left standing after chip select rises
    always_ff @(posedge spi_clk or negedge nrst) begin
        if (!nrst)
            lk_cnt <= CNT_ZERO;
        else if (fresh)
            lk_cnt <= CNT_ONE;
        else if (lk_cnt != {CNT_W{1'b1}})
            lk_cnt <= lk_cnt + CNT_ONE;
    end

    always_ff @(posedge spi_clk or negedge nrst) begin
        if (!nrst)
            lk_op <= 8'h00;
        else if (fresh)
            lk_op <= {7'h00, spi_di};
        else if (lk_cnt < CMD_BITS)
            lk_op <= {lk_op[6:0], spi_di};
    end

    // up to 32 bits after the opcode are kept
    always_ff @(posedge spi_clk or negedge nrst) begin
        if (!nrst)
            lk_addr <= 32'h0000_0000;
        else if (fresh)
            lk_addr <= 32'h0000_0000;
        else if (lk_cnt >= CMD_BITS && lk_cnt < CAP_CLKS)
            lk_addr <= {lk_addr[30:0], spi_di};
    end

    sfe_sync2 #(
        .W(16),
        .RST_VAL(16'h0000)
    ) u_st_sync (
        .clk(spi_clk),
        .nrst(nrst),
        .d(st_word),
        .q(lk_status)
    );

    // status byte shifted out msb first on falling edges, repeating
    always_ff @(negedge spi_clk or negedge nrst) begin
        if (!nrst)
            rd_on <= 1'b0;
        else if (spi_cs_n)
            rd_on <= 1'b0;
        else
            rd_on <= (lk_cnt >= CMD_BITS) &&
                     (lk_op == OP_RDSR1 || lk_op == OP_RDSR2); // [RULE12]
    end

    always_ff @(negedge spi_clk or negedge nrst) begin
        if (!nrst)
            spi_do <= 1'b0;
        else if (lk_op == OP_RDSR2)
            spi_do <= lk_status[4'h8 + {1'b0, ~lk_cnt[2:0]}];
        else
            spi_do <= lk_status[{1'b0, ~lk_cnt[2:0]}]; // [RULE12]
    end

    assign spi_do_oe_n = spi_cs_n | ~rd_on;

    // ---------------- system domain ----------------
    logic cs_s;
    logic cs_q;
    logic cs_rise;
    sfe_state_e st;
    logic [31:0] remain;
    logic [CNT_W-1:0] wait_cnt;
    sfe_kind_e act_kind;
    logic [31:0] act_base;
    logic [31:0] act_len;
    logic sav_valid;
    sfe_kind_e sav_kind;
    logic [31:0] sav_remain;
    logic [31:0] sav_base;
    logic [31:0] sav_len;
    logic dv;
    logic dok;
    sfe_cmd_e dcmd;
    sfe_kind_e dkind;
    logic [31:0] dbase;
    logic [31:0] dlen;
    sfe_cmd_e next_cmd;
    sfe_kind_e next_kind;
    logic next_ok;
    logic [31:0] next_base;
    logic [CNT_W-1:0] abits;
    logic quad;
    logic [31:0] raw_addr;
    logic blk;
    logic ovl;
    logic start_ok;
    logic susp_ok;
    logic resm_ok;
    logic done;

    sfe_sync2 #(
        .W(1),
        .RST_VAL(1'b1)
    ) u_cs_sync (
        .clk(clk_sys),
        .nrst(nrst),
        .d(spi_cs_n),
        .q(cs_s)
    );

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            cs_q <= 1'b1;
        else
            cs_q <= cs_s;
    end

    // link registers are frozen once chip select is high
    assign cs_rise = cs_s & ~cs_q;

    always_comb begin
        next_cmd = CMD_NONE;
        next_kind = KD_PP;
        abits = addr4_mode ? ADDR4_BITS : ADDR3_BITS; // [RULE9]
        quad = 1'b0;
        case (lk_op)
            OP_SE: begin
                next_cmd = CMD_ERASE;
                next_kind = KD_SE; // [RULE2]
            end
            OP_SE4: begin
                next_cmd = CMD_ERASE;
                next_kind = KD_SE;
                abits = ADDR4_BITS; // [RULE3]
            end
            OP_BE32: begin
                next_cmd = CMD_ERASE;
                next_kind = KD_B32; // [RULE4]
            end
            OP_BE64: begin
                next_cmd = CMD_ERASE;
                next_kind = KD_B64; // [RULE5]
            end
            OP_BE64_4: begin
                next_cmd = CMD_ERASE;
                next_kind = KD_B64;
                abits = ADDR4_BITS; // [RULE6]
            end
            OP_CE1, OP_CE2: begin
                next_cmd = CMD_ERASE;
                next_kind = KD_CE; // [RULE7]
                abits = CNT_ZERO;
            end
            OP_PP: next_cmd = CMD_PROG;
            OP_PP4: begin
                next_cmd = CMD_PROG;
                abits = ADDR4_BITS;
            end
            OP_QPP: begin
                next_cmd = CMD_PROG;
                quad = 1'b1;
            end
            OP_QPP4: begin
                next_cmd = CMD_PROG;
                quad = 1'b1;
                abits = ADDR4_BITS; // [RULE1]
            end
            OP_WREN: begin
                next_cmd = CMD_WREN;
                abits = CNT_ZERO;
            end
            OP_WRDI: begin
                next_cmd = CMD_WRDI;
                abits = CNT_ZERO;
            end
            OP_SUSP: begin
                next_cmd = CMD_SUSP;
                abits = CNT_ZERO;
            end
            OP_RESM: begin
                next_cmd = CMD_RESM;
                abits = CNT_ZERO;
            end
            default: next_cmd = CMD_NONE;
        endcase
        // frames of 40 clocks or more carry a data byte behind a 24-bit address
        if (abits == ADDR4_BITS)
            raw_addr = lk_addr;
        else if (lk_cnt >= CAP_CLKS)
            raw_addr = {8'h00, lk_addr[31:8]};
        else
            raw_addr = {8'h00, lk_addr[23:0]};
        next_base = raw_addr & ~(kind_len(next_kind) - 32'h0000_0001);
        if (next_kind == KD_PP)
            next_base = raw_addr;
        next_ok = frame_ok(lk_cnt, CMD_BITS + abits,
                           next_cmd != CMD_PROG, quad) // [RULE10]
                  && (!quad || quad_io_enable); // [RULE24]
    end

    // decode stage; protection lookup must answer in the same cycle as dv
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dv <= 1'b0;
            dok <= 1'b0;
            dcmd <= CMD_NONE;
            dkind <= KD_PP;
            dbase <= 32'h0000_0000;
            dlen <= 32'h0000_0000;
        end else begin
            dv <= cs_rise;
            if (cs_rise) begin
                dok <= next_ok;
                dcmd <= next_cmd;
                dkind <= next_kind;
                dbase <= next_base;
                dlen <= kind_len(next_kind);
            end
        end
    end

    assign prot_addr = dbase;
    assign prot_len = dlen;
    assign prot_whole = (dkind == KD_CE);

    // suspended erase bars erases; suspended program bars programs
    assign blk = paused_flag && // [RULE18] [RULE19]
                 ((dcmd == CMD_ERASE) == (sav_kind != KD_PP));
    assign ovl = sav_valid && (dkind == KD_CE ||
                 (dbase < sav_base + sav_len &&
                  sav_base < dbase + dlen)); // [RULE22]
    assign start_ok = dv && dok && (dcmd == CMD_ERASE || dcmd == CMD_PROG)
                      && write_enable_latch // [RULE8]
                      && st == ST_IDLE && !prot_hit // [RULE14]
                      && !blk && !ovl; // [RULE25]
    assign susp_ok = dv && dok && dcmd == CMD_SUSP && st == ST_RUN
                     && !paused_flag // [RULE15]
                     && act_kind != KD_CE; // [RULE16]
    assign resm_ok = dv && dok && dcmd == CMD_RESM && paused_flag
                     && st == ST_IDLE; // [RULE23]
    assign done = (st == ST_RUN) && (remain == 32'h0000_0001) && !susp_ok;
    assign busy = (st == ST_RUN) || (st == ST_PAUSING); // [RULE11]

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= ST_IDLE;
            remain <= 32'h0000_0000;
            wait_cnt <= CNT_ZERO;
            act_kind <= KD_PP;
            act_base <= 32'h0000_0000;
            act_len <= 32'h0000_0000;
        end else begin
            case (st)
                ST_IDLE: begin
                    if (start_ok) begin
                        st <= ST_RUN; // [RULE11]
                        remain <= kind_cyc(dkind);
                        act_kind <= dkind;
                        act_base <= dbase;
                        act_len <= dlen;
                    end else if (resm_ok) begin
                        st <= ST_RESUMING;
                        wait_cnt <= RESUME_CYC; // [RULE23]
                    end
                end
                ST_RUN: begin
                    if (susp_ok) begin
                        st <= ST_PAUSING;
                        wait_cnt <= PAUSE_CYC; // [RULE17]
                    end else if (done)
                        st <= ST_IDLE;
                    else
                        remain <= remain - 32'h0000_0001;
                end
                ST_PAUSING: begin
                    if (wait_cnt == CNT_ONE)
                        st <= ST_IDLE; // [RULE17]
                    else
                        wait_cnt <= wait_cnt - CNT_ONE;
                end
                ST_RESUMING: begin
                    if (wait_cnt == CNT_ONE) begin
                        st <= ST_RUN;
                        remain <= sav_remain;
                        act_kind <= sav_kind;
                        act_base <= sav_base;
                        act_len <= sav_len;
                    end else
                        wait_cnt <= wait_cnt - CNT_ONE;
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // the interrupted operation parked while other work may run
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sav_valid <= 1'b0;
            sav_kind <= KD_PP;
            sav_remain <= 32'h0000_0000;
            sav_base <= 32'h0000_0000;
            sav_len <= 32'h0000_0000;
        end else if (st == ST_PAUSING && wait_cnt == CNT_ONE) begin
            sav_valid <= 1'b1;
            sav_kind <= act_kind;
            sav_remain <= remain;
            sav_base <= act_base;
            sav_len <= act_len;
        end else if (st == ST_RESUMING && wait_cnt == CNT_ONE)
            sav_valid <= 1'b0;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            write_enable_latch <= 1'b0;
        else if (done)
            write_enable_latch <= 1'b0; // [RULE13]
        else if (dv && dok && st == ST_IDLE && dcmd == CMD_WREN)
            write_enable_latch <= 1'b1;
        else if (dv && dok && st == ST_IDLE && dcmd == CMD_WRDI)
            write_enable_latch <= 1'b0;
    end

    // power loss is the reset: the pause is released and the flag cleared
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            paused_flag <= 1'b0; // [RULE21]
        else if (susp_ok)
            paused_flag <= 1'b1; // [RULE17]
        else if (resm_ok)
            paused_flag <= 1'b0; // [RULE23]
    end

    always_comb begin
        next_st_word = 16'h0000;
        next_st_word[SR1_BUSY] = busy;
        next_st_word[SR1_WEL] = write_enable_latch;
        next_st_word[SR1_BP0] = protect_range_bit0;
        next_st_word[SR1_BP1] = protect_range_bit1;
        next_st_word[SR1_BP2] = protect_range_bit2;
        next_st_word[SR1_BP3] = protect_range_bit3;
        next_st_word[SR1_TB] = protect_top_bottom;
        next_st_word[SR2_QE] = quad_io_enable;
        next_st_word[SR2_CMP] = protect_complement;
        next_st_word[SR2_SUS] = paused_flag;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            st_word <= 16'h0000;
        else
            st_word <= next_st_word;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            op_start <= 1'b0;
            op_erase <= 1'b0;
            op_base <= 32'h0000_0000;
            op_len <= 32'h0000_0000;
            op_fill <= ERASE_FILL;
            op_paused <= 1'b0;
            op_done <= 1'b0;
        end else begin
            op_start <= start_ok;
            op_done <= done;
            op_paused <= sav_valid;
            if (start_ok) begin
                op_erase <= (dkind != KD_PP);
                op_base <= dbase;
                op_len <= dlen;
                op_fill <= ERASE_FILL; // [RULE2] [RULE4] [RULE5] [RULE7]
            end
        end
    end
endmodule

// ### inc/sfe_pkg.sv
// Summary of operation
// [RULE1] Quad page program with 4-byte opcode always takes a 32-bit address.
// [RULE2] Sector erase sets every byte of the addressed 4K sector to all ones.
// [RULE3] Sector erase with 4-byte opcode always takes a 32-bit address.
// [RULE4] Small block erase sets the whole addressed 32K block to all ones.
// [RULE5] Large block erase sets the whole addressed 64K block to all ones.
// [RULE6] 64K block erase with 4-byte opcode always takes a 32-bit address.
// [RULE7] Either whole-array opcode, sent with no address, erases everything.
// [RULE8] Erase opcodes run only while the write enable latch is set.
// [RULE9] Mode-dependent address: 24 bits in 3-byte mode, 32 in 4-byte mode.
// [RULE10] Chip select must rise on a byte boundary, else erase is dropped.
// [RULE11] After chip select rises the erase self-times with busy held high.
// [RULE12] Status reads stay available during an erase so busy can be polled.
// [RULE13] Finishing any erase clears the write enable latch.
// [RULE14] Protected target refuses erase; whole array needs none protected.
// [RULE15] Suspend taken only unpaused and busy, erasing or programming.
// [RULE16] Suspend during a whole-array erase is ignored and the erase goes on.
// [RULE17] Suspend sets paused flag at once; busy drops within pause latency.
// [RULE18] Erase suspended: status writes and all erase opcodes are refused.
// [RULE19] Program suspended: status writes and page program opcodes are refused.
// [RULE20] Host waits suspend latency after a resume before suspending again.
// [RULE21] Power loss while paused resets and clears the paused flag.
// [RULE22] While paused, other sectors may be read, programmed or erased.
// [RULE23] Resume clears paused flag at once and raises busy within 200 ns.
// [RULE24] Quad page program opcodes need the quad I/O enable bit set.
// [RULE25] Refused opcodes leave status bits and array contents unchanged.
package sfe_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int NS_PER_US = 1000;

    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_PP4 = 8'h12;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_SE4 = 8'h21;
    localparam logic [7:0] OP_QPP = 8'h32;
    localparam logic [7:0] OP_QPP4 = 8'h34;
    localparam logic [7:0] OP_RDSR2 = 8'h35;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_CE2 = 8'h60;
    localparam logic [7:0] OP_SUSP = 8'h75;
    localparam logic [7:0] OP_RESM = 8'h7A;
    localparam logic [7:0] OP_CE1 = 8'hC7;
    localparam logic [7:0] OP_BE64 = 8'hD8;
    localparam logic [7:0] OP_BE64_4 = 8'hDC;

    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CMD_BITS = 16'h0008;
    localparam logic [CNT_W-1:0] ADDR3_BITS = 16'h0018;
    localparam logic [CNT_W-1:0] ADDR4_BITS = 16'h0020;
    localparam logic [CNT_W-1:0] BYTE_CLKS = 16'h0008;
    localparam logic [CNT_W-1:0] QUAD_BYTE_CLKS = 16'h0002;
    localparam logic [CNT_W-1:0] CAP_CLKS = 16'h0028;

    localparam logic [31:0] SECTOR_BYTES = 32'h0000_1000;
    localparam logic [31:0] BLK32_BYTES = 32'h0000_8000;
    localparam logic [31:0] BLK64_BYTES = 32'h0001_0000;
    localparam logic [31:0] PAGE_BYTES = 32'h0000_0100;
    localparam logic [31:0] ARRAY_BYTES = 32'h0200_0000;
    localparam logic [7:0] ERASE_FILL = 8'hFF;

    // resume and pause latencies are upper bounds: round down, floor of one
    localparam int RESUME_NS = 200;
    localparam int RESUME_I = RESUME_NS / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] RESUME_CYC =
        CNT_W'((RESUME_I > 0) ? RESUME_I : 1);
    localparam int PAUSE_ENTRY_LATENCY_NS = 20000;
    localparam int PAUSE_I = PAUSE_ENTRY_LATENCY_NS / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] PAUSE_CYC =
        CNT_W'((PAUSE_I > 0) ? PAUSE_I : 1);

    localparam int SR1_BUSY = 0;
    localparam int SR1_WEL = 1;
    localparam int SR1_BP0 = 2;
    localparam int SR1_BP1 = 3;
    localparam int SR1_BP2 = 4;
    localparam int SR1_BP3 = 5;
    localparam int SR1_TB = 6;
    localparam int SR2_QE = 9;
    localparam int SR2_CMP = 14;
    localparam int SR2_SUS = 15;

    typedef enum logic [4:0] {
        KD_SE = 5'h01,
        KD_B32 = 5'h02,
        KD_B64 = 5'h04,
        KD_CE = 5'h08,
        KD_PP = 5'h10
    } sfe_kind_e;

    typedef enum logic [6:0] {
        CMD_NONE = 7'h01,
        CMD_ERASE = 7'h02,
        CMD_PROG = 7'h04,
        CMD_WREN = 7'h08,
        CMD_WRDI = 7'h10,
        CMD_SUSP = 7'h20,
        CMD_RESM = 7'h40
    } sfe_cmd_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RUN = 4'h2,
        ST_PAUSING = 4'h4,
        ST_RESUMING = 4'h8
    } sfe_state_e;

    function automatic logic [31:0] us_to_cyc(input int unsigned us);
        logic [63:0] c;
        c = 64'(us) * 64'(NS_PER_US) / 64'(CLK_PERIOD_NS);
        return (c == 64'h0) ? 32'h0000_0001 : c[31:0];
    endfunction
endpackage

// ### rtl/sfe_sync2.sv
`timescale 1ns/1ps
module sfe_sync2
    import sfe_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset of the receiving domain
    input wire logic clk,
    input wire logic nrst,
    // crossing data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ### verif/sfe_sva.sv
`timescale 1ns/1ps
module sfe_sva (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // link
    input wire logic spi_cs_n,
    input wire logic spi_do_oe_n,
    // status and engine
    input wire logic busy,
    input wire logic write_enable_latch,
    input wire logic paused_flag,
    input wire logic op_start,
    input wire logic op_done,
    input wire logic [7:0] op_fill
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    sequence s_drop;
        ##[1:205] !busy;
    endsequence
    sequence s_back;
        ##[1:3] busy;
    endsequence
    a_fill_ones: assert property (op_start |-> op_fill == 8'hFF)
        else $error("erase fill is not all ones");
    a_start_wel: assert property (op_start |-> write_enable_latch)
        else $error("operation started without write enable");
    a_start_busy: assert property (op_start |-> ##[0:1] busy)
        else $error("busy missing after start");
    a_done_clear: assert property (op_done |->
        !busy && !write_enable_latch)
        else $error("busy or write enable left set at end");
    a_pause_hold: assert property ($rose(paused_flag) |-> busy[*8])
        else $error("busy dropped at once on pause");
    a_pause_drop: assert property ($rose(paused_flag) |-> s_drop)
        else $error("busy not cleared within pause latency");
    a_resume_busy: assert property ($fell(paused_flag) |-> s_back)
        else $error("busy not raised after resume");
    a_idle_quiet: assert property (spi_cs_n |-> spi_do_oe_n)
        else $error("output driven while deselected");
endmodule
bind sfe_ctrl sfe_sva sfe_sva_i (.clk_sys, .nrst, .spi_cs_n, .spi_do_oe_n,
    .busy, .write_enable_latch, .paused_flag, .op_start, .op_done, .op_fill);

// ### verif/sfe_host.sv
`timescale 1ns/1ps
module sfe_host (
    // link toward the device
    output logic spi_clk,
    output logic spi_cs_n,
    output logic spi_di,
    input wire logic spi_do
);
    initial begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_di = 1'b0;
    end
    // opcode, na address bits, nx trailing clocks; last 8 do bits kept
    task automatic xfer(input logic [7:0] op, input logic [31:0] a,
        input int na, input int nx, output logic [7:0] st);
        logic [71:0] v;
        v = {op, a << (32 - na), 32'h0};
        st = 8'h00;
        spi_cs_n = 1'b0;
        for (int i = 0; i < 8 + na + nx; i++) begin
            spi_di = v[71 - i];
            #62.5 spi_clk = 1'b1;
            st = {st[6:0], spi_do};
            #62.5 spi_clk = 1'b0;
        end
        spi_cs_n = 1'b1;
        spi_di = ~spi_di;
        #700;
    endtask
endmodule

// ### verif/sfe_ctrl_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module sfe_ctrl_bench;
    import sfe_pkg::*;
    logic clk_sys, nrst, addr4_mode, quad_io_enable, prot_hit;
    logic [5:0] pb;
    logic [7:0] st;
    wire logic spi_clk, spi_cs_n, spi_di, spi_do, spi_do_oe_n, prot_whole;
    wire logic busy, write_enable_latch, paused_flag, op_start, op_erase;
    wire logic op_paused, op_done;
    wire logic [31:0] prot_addr, prot_len, op_base, op_len;
    wire logic [7:0] op_fill;
    int n_fail = 0, tests_run = 0, n_start = 0;
    sfe_ctrl #(.SE_TIME_US(5), .B32_TIME_US(6), .B64_TIME_US(7),
        .CE_TIME_US(5), .PP_TIME_US(5)) sfe_ctrl_i (.clk_sys, .nrst,
        .spi_clk, .spi_cs_n, .spi_di, .spi_do, .spi_do_oe_n, .addr4_mode,
        .quad_io_enable, .protect_complement(pb[5]),
        .protect_top_bottom(pb[4]), .protect_range_bit3(pb[3]),
        .protect_range_bit2(pb[2]), .protect_range_bit1(pb[1]),
        .protect_range_bit0(pb[0]), .prot_addr, .prot_len, .prot_whole,
        .prot_hit, .busy, .write_enable_latch, .paused_flag, .op_start,
        .op_erase, .op_base, .op_len, .op_fill, .op_paused, .op_done);
    sfe_host sfe_host_i (.spi_clk, .spi_cs_n, .spi_di, .spi_do);
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (op_start === 1'b1) n_start++;
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask
    task cmd(input logic [7:0] op, input logic [31:0] a, input int na);
        sfe_host_i.xfer(op, a, na, 0, st);
    endtask
    task wait_done;
        repeat (3000) begin
            @(posedge clk_sys);
            #1;
            if (op_done === 1'b1) break;
        end
        `CHK(op_done, 1'b1);
        `CHK(write_enable_latch, 1'b0);
    endtask
    task t_no(input logic [7:0] op, input int na, input int nx);
        int s;
        s = n_start;
        sfe_host_i.xfer(op, 32'h0001_0000, na, nx, st);
        `CHK(n_start, s);
    endtask
    task t_table;
        logic [7:0] op [9] = '{OP_SE, OP_SE, OP_SE4, OP_BE32, OP_BE64,
            OP_BE64_4, OP_CE1, OP_CE2, OP_QPP4};
        int na [9] = '{24, 32, 32, 24, 32, 32, 0, 0, 32};
        logic [31:0] ln [9] = '{SECTOR_BYTES, SECTOR_BYTES, SECTOR_BYTES,
            BLK32_BYTES, BLK64_BYTES, BLK64_BYTES, ARRAY_BYTES, ARRAY_BYTES,
            PAGE_BYTES};
        logic [31:0] a;
        for (int i = 0; i < 9; i++) begin
            tick(1);
            addr4_mode = (i == 1) || (i == 4);
            a = (na[i] == 24) ? 32'h0034_5678 : 32'h0134_5678;
            cmd(OP_WREN, 0, 0);
            sfe_host_i.xfer(op[i], a, na[i], (i == 8) ? 2 : 0, st);
            a = (i == 8) ? a : a & ~(ln[i] - 1);
            `CHK(op_base, a);
            `CHK(op_len, ln[i]);
            `CHK(op_erase, i != 8);
            sfe_host_i.xfer(OP_RDSR1, 0, 0, 8, st);
            `CHK(st, {1'b0, pb[4:0], 2'b11});
            wait_done();
        end
    endtask
    task t_refuse;
        t_no(OP_SE, 24, 0);
        cmd(OP_WREN, 0, 0);
        t_no(OP_SE, 24, 1);
        prot_hit = 1'b1;
        t_no(OP_CE2, 0, 0);
        prot_hit = 1'b0;
        quad_io_enable = 1'b0;
        t_no(OP_QPP4, 32, 2);
        quad_io_enable = 1'b1;
        `CHK(write_enable_latch, 1'b1);
    endtask
    task t_pause;
        cmd(OP_SE, 32'h0000_2000, 24);
        cmd(OP_SUSP, 0, 0);
        `CHK(paused_flag & busy, 1'b1);
        tick(200);
        `CHK({op_paused, busy}, 2'b10);
        t_no(OP_BE64, 24, 0);
        cmd(OP_RESM, 0, 0);
        `CHK(paused_flag, 1'b0);
        `CHK(busy, 1'b1);
        wait_done();
        cmd(OP_WREN, 0, 0);
        cmd(OP_CE1, 0, 0);
        cmd(OP_SUSP, 0, 0);
        `CHK(paused_flag, 1'b0);
        wait_done();
        cmd(OP_WREN, 0, 0);
        cmd(OP_SE, 32'h0000_3000, 24);
        cmd(OP_SUSP, 0, 0);
        tick(1);
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        `CHK(paused_flag | op_paused, 1'b0);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #1_000_000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        nrst = 1'b0;
        addr4_mode = 1'b0;
        quad_io_enable = 1'b1;
        prot_hit = 1'b0;
        pb = 6'h15;
        tick(6);
        nrst = 1'b1;
        tick(2);
        t_table();
        t_refuse();
        t_pause();
        tally_and_finish();
    end
endmodule
